// ---- id_cap_pkg.sv ----
// Constants, field layouts and types of the identity and capability bank
package id_cap_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [11:0] PART_IDENTITY_INFO_OFS     = 12'h004;
	localparam logic [11:0] MEMORY_SIZE_CAPABILITY_OFS = 12'h008;

	// ------------------------------------------------------------------
	// Field positions (least significant bit of each field)
	// ------------------------------------------------------------------
	localparam int FORMAT_VERSION_LSB = 28; // Bits 31:28
	localparam int FAMILY_CODE_LSB    = 24; // Bits 27:24
	localparam int PART_NUMBER_LSB    = 16; // Bits 23:16
	localparam int ID_RESERVED_LSB    = 8;  // Bits 15:8
	localparam int TEMP_GRADE_LSB     = 5;  // Bits 7:5
	localparam int PACKAGE_TYPE_LSB   = 3;  // Bits 4:3
	localparam int COMPLIANCE_BIT     = 2;  // Bit 2
	localparam int QUALIFY_STATUS_LSB = 0;  // Bits 1:0
	localparam int RAM_SIZE_LSB       = 16; // Bits 31:16
	localparam int FLASH_SIZE_LSB     = 0;  // Bits 15:0

	// ------------------------------------------------------------------
	// Fixed silicon values
	// ------------------------------------------------------------------
	localparam logic [1:0]  PACKAGE_QFP48_CODE   = 2'h1;
	localparam logic        COMPLIANCE_SET       = 1'h1;
	localparam logic [7:0]  ID_RESERVED_VALUE    = 8'h00;
	localparam logic [15:0] RAM_SIZE_2KB_CODE    = 16'h0007;
	localparam logic [15:0] FLASH_SIZE_16KB_CODE = 16'h0007;
	localparam logic [31:0] READ_DATA_RESET      = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		TEMP_COMMERCIAL = 3'b000,
		TEMP_INDUSTRIAL = 3'b001
	} temp_grade_e;

	typedef enum logic [1:0] {
		QUALIFY_ENGINEERING = 2'b00,
		QUALIFY_PILOT       = 2'b01,
		QUALIFY_FULL        = 2'b10
	} qualify_status_e;

	// Register selected by an address
	typedef enum logic [1:0] {
		SEL_NONE     = 2'b00,
		SEL_IDENTITY = 2'b01,
		SEL_MEMCAP   = 2'b10
	} reg_sel_e;

	// ------------------------------------------------------------------
	// Register layouts
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0]   format_version_field;
		logic [3:0]   family_code_field;
		logic [7:0]   part_number_field;
		logic [7:0]   reserved;
		temp_grade_e  temp_grade_field;
		logic [1:0]   package_type_field;
		logic         substance_compliance_flag;
		qualify_status_e qualification_status_field;
	} part_identity_info_s;

	typedef struct packed {
		logic [15:0] ram_size_field;
		logic [15:0] flash_size_field;
	} memory_size_capability_s;

endpackage

// ---- id_cap_regs.sv ----
// APB slave holding the read-only part identity and memory size registers
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns

module id_cap_regs #(
	parameter int          ADDR_W         = 12,
	parameter logic [3:0]  FORMAT_VERSION = 4'h1,  // Arbitrary value
	parameter logic [3:0]  FAMILY_CODE    = 4'h5,  // Arbitrary value
	parameter logic [7:0]  PART_NUMBER    = 8'h3c, // Arbitrary value
	parameter logic [2:0]  TEMP_GRADE     = 3'b000,
	parameter logic [1:0]  QUALIFY_STATUS = 2'b10
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB request
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	// APB answer
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// Offsets need 4 address bits; reserved grade and status codes
	// would misreport the part, so they are refused here.
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 4 and 32");
	end
	if (TEMP_GRADE > 3'b001) begin : g_bad_temp
		$error("TEMP_GRADE must be commercial or industrial");
	end
	if (QUALIFY_STATUS == 2'b11) begin : g_bad_qualify
		$error("QUALIFY_STATUS must not be the reserved code");
	end

	// ------------------------------------------------------------------
	// Fixed register contents
	// ------------------------------------------------------------------
	id_cap_pkg::part_identity_info_s     ident;  // Identity word
	id_cap_pkg::memory_size_capability_s memcap; // Memory size word

	// Hard-wired fields: no flop holds them, so no write path exists
	always_comb begin
		ident.format_version_field      = FORMAT_VERSION;
		ident.family_code_field         = FAMILY_CODE;
		ident.part_number_field         = PART_NUMBER;
		ident.reserved                  =
			id_cap_pkg::ID_RESERVED_VALUE;
		ident.temp_grade_field          =
			id_cap_pkg::temp_grade_e'(TEMP_GRADE);
		ident.package_type_field        =
			id_cap_pkg::PACKAGE_QFP48_CODE;
		ident.substance_compliance_flag =
			id_cap_pkg::COMPLIANCE_SET;
		ident.qualification_status_field =
			id_cap_pkg::qualify_status_e'(QUALIFY_STATUS);
		memcap.ram_size_field   = id_cap_pkg::RAM_SIZE_2KB_CODE;
		memcap.flash_size_field = id_cap_pkg::FLASH_SIZE_16KB_CODE;
	end

	// ------------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------------
	// Full-width compare: aliases would hide software address bugs
	function automatic id_cap_pkg::reg_sel_e decode(
		input logic [ADDR_W-1:0] addr
	);
		logic [31:0] a;
		a = 32'(addr);
		if (a == 32'(id_cap_pkg::PART_IDENTITY_INFO_OFS)) begin
			decode = id_cap_pkg::SEL_IDENTITY;
		end else if (a == 32'(id_cap_pkg::MEMORY_SIZE_CAPABILITY_OFS)) begin
			decode = id_cap_pkg::SEL_MEMCAP;
		end else begin
			decode = id_cap_pkg::SEL_NONE;
		end
	endfunction

	id_cap_pkg::reg_sel_e sel;       // Register the request points at
	logic                 setup;     // Setup phase of a transfer
	logic [31:0]          rdata_nxt; // Word to present in access phase

	assign sel   = decode(paddr);
	assign setup = psel && !penable;

	// Read mux; unmapped and write cycles return zero
	always_comb begin
		rdata_nxt = id_cap_pkg::READ_DATA_RESET;
		if (!pwrite && sel == id_cap_pkg::SEL_IDENTITY) begin
			rdata_nxt = ident;
		end else if (!pwrite && sel == id_cap_pkg::SEL_MEMCAP) begin
			rdata_nxt = memcap;
		end
	end

	// ------------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------------
	logic [31:0] prdata_r;  // Read data flop
	logic        pslverr_r; // Error flag flop

	// No wait states: data is staged during setup, so access is final
	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	// Read data captured at the end of setup, held until the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= id_cap_pkg::READ_DATA_RESET;
		end else if (setup) begin
			prdata_r <= rdata_nxt;
		end
	end

	// Error only for unmapped addresses; a write to a mapped register
	// completes cleanly and is dropped, pwdata and pstrb go nowhere
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else if (setup) begin
			pslverr_r <= (sel == id_cap_pkg::SEL_NONE);
		end else begin
			pslverr_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	logic rd_id;  // Access phase of an identity read
	logic rd_mem; // Access phase of a capability read

	assign rd_id  = psel && penable && !pwrite &&
		sel == id_cap_pkg::SEL_IDENTITY;
	assign rd_mem = psel && penable && !pwrite &&
		sel == id_cap_pkg::SEL_MEMCAP;

	property p_version;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[31:id_cap_pkg::FORMAT_VERSION_LSB] ==
			FORMAT_VERSION;
	endproperty
	a_version: assert property (p_version)
		else $error("Format version field wrong");

	property p_family;
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && sel == id_cap_pkg::SEL_IDENTITY) ##1 penable
		|-> prdata[27:id_cap_pkg::FAMILY_CODE_LSB] == FAMILY_CODE;
	endproperty
	a_family: assert property (p_family)
		else $error("Family code field wrong");

	property p_part;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[23:id_cap_pkg::PART_NUMBER_LSB] == PART_NUMBER &&
			!pslverr && pready;
	endproperty
	a_part: assert property (p_part)
		else $error("Part number field wrong");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[15:id_cap_pkg::ID_RESERVED_LSB] ==
			id_cap_pkg::ID_RESERVED_VALUE;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("Reserved identity bits not zero");

	property p_temp;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[7:id_cap_pkg::TEMP_GRADE_LSB] == TEMP_GRADE &&
			prdata[7:6] == 2'h0;
	endproperty
	a_temp: assert property (p_temp)
		else $error("Temperature grade wrong or reserved");

	property p_package;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[4:id_cap_pkg::PACKAGE_TYPE_LSB] == 2'h1;
	endproperty
	a_package: assert property (p_package)
		else $error("Package type not the 48-pin code");

	property p_compliance;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[id_cap_pkg::COMPLIANCE_BIT];
	endproperty
	a_compliance: assert property (p_compliance)
		else $error("Compliance flag not set");

	property p_qualify;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[1:id_cap_pkg::QUALIFY_STATUS_LSB] ==
			QUALIFY_STATUS && prdata[1:0] != 2'h3;
	endproperty
	a_qualify: assert property (p_qualify)
		else $error("Qualification status wrong");

	property p_memcap;
		@(posedge pclk) disable iff (!presetn)
		rd_mem |-> prdata == 32'h0007_0007 && !pslverr;
	endproperty
	a_memcap: assert property (p_memcap)
		else $error("Capability word not preset value");

	property p_ram;
		@(posedge pclk) disable iff (!presetn)
		rd_mem |-> prdata[31:id_cap_pkg::RAM_SIZE_LSB] == 16'h0007;
	endproperty
	a_ram: assert property (p_ram)
		else $error("RAM size code wrong");

	property p_flash;
		@(posedge pclk) disable iff (!presetn)
		rd_mem |-> prdata[15:id_cap_pkg::FLASH_SIZE_LSB] == 16'h0007;
	endproperty
	a_flash: assert property (p_flash)
		else $error("Flash size code wrong");

	property p_write_ignored;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && sel != id_cap_pkg::SEL_NONE)
		##1 (setup && !pwrite && sel == id_cap_pkg::SEL_IDENTITY)
		|=> prdata == ident_exp && prdata[2];
	endproperty
	a_write_ignored: assert property (p_write_ignored)
		else $error("Register changed after a write");

	property p_write_ok;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && sel != id_cap_pkg::SEL_NONE)
		|-> !pslverr && prdata == 32'h0;
	endproperty
	a_write_ok: assert property (p_write_ok)
		else $error("Mapped write answered with error or data");

	// ------------------------------------------------------------------
	// Whole-word and bus protocol checks
	// ------------------------------------------------------------------
	// Built field by field from the parameters, not from the read mux,
	// so a slip in the struct layout shows up here
	logic [31:0] ident_exp; // Expected identity word

	assign ident_exp = {FORMAT_VERSION, FAMILY_CODE, PART_NUMBER,
		id_cap_pkg::ID_RESERVED_VALUE, TEMP_GRADE,
		id_cap_pkg::PACKAGE_QFP48_CODE, id_cap_pkg::COMPLIANCE_SET,
		QUALIFY_STATUS};

	property p_ident_word;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata == ident_exp;
	endproperty
	a_ident_word: assert property (p_ident_word)
		else $error("Identity word wrong");

	property p_grade_legal;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> prdata[7:5] == 3'b000 || prdata[7:5] == 3'b001;
	endproperty
	a_grade_legal: assert property (p_grade_legal)
		else $error("Reserved temperature grade read");

	property p_id_no_err;
		@(posedge pclk) disable iff (!presetn)
		rd_id |-> !pslverr && pready;
	endproperty
	a_id_no_err: assert property (p_id_no_err)
		else $error("Identity read answered with error");

	property p_mem_word;
		@(posedge pclk) disable iff (!presetn)
		rd_mem |-> prdata == {id_cap_pkg::RAM_SIZE_2KB_CODE,
			id_cap_pkg::FLASH_SIZE_16KB_CODE};
	endproperty
	a_mem_word: assert property (p_mem_word)
		else $error("Capability word wrong");

	// Zero wait states: every access phase must complete at once
	property p_always_ready;
		@(posedge pclk) disable iff (!presetn)
		psel && penable |-> pready;
	endproperty
	a_always_ready: assert property (p_always_ready)
		else $error("Access phase not ready");

	property p_idle_quiet;
		@(posedge pclk) disable iff (!presetn)
		!psel |-> !pslverr && pready;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("Error shown on an idle bus");

	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && sel == id_cap_pkg::SEL_NONE
		|-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("Unmapped access not refused");

	property p_mapped_ok;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && sel != id_cap_pkg::SEL_NONE |-> !pslverr;
	endproperty
	a_mapped_ok: assert property (p_mapped_ok)
		else $error("Mapped access answered with error");

	// The error must last one access cycle only, never into the next
	property p_err_drops;
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable) |-> !pslverr;
	endproperty
	a_err_drops: assert property (p_err_drops)
		else $error("Error outside an access phase");

	// Read data may only move after a setup edge
	property p_data_holds;
		@(posedge pclk) disable iff (!presetn)
		!$past(setup) |-> $stable(prdata);
	endproperty
	a_data_holds: assert property (p_data_holds)
		else $error("Read data moved without a setup");

	property p_write_no_data;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite |-> prdata == 32'h0;
	endproperty
	a_write_no_data: assert property (p_write_no_data)
		else $error("Write cycle returned data");

endmodule // id_cap_regs

// ---- device_identity_capability_regs_bench.sv ----
// Self-checking bench for the identity and capability register bank
`timescale 1ns/1ns

module device_identity_capability_regs_bench;

	// ----------------------------------------------------------------
	// Variants under test
	// ----------------------------------------------------------------
	localparam logic [3:0]  FV   = 4'h1;  // Arbitrary value
	localparam logic [3:0]  FC   = 4'h5;  // Arbitrary value
	localparam logic [7:0]  PN   = 8'h3c; // Arbitrary value
	// Grade and status per variant, variant 0 in the lowest slice
	localparam logic [8:0]  TG   = {3'h0, 3'h1, 3'h0};
	localparam logic [5:0]  QS   = {2'h0, 2'h1, 2'h2};
	localparam logic [11:0] ID_A = id_cap_pkg::PART_IDENTITY_INFO_OFS;
	localparam logic [11:0] MC_A = id_cap_pkg::MEMORY_SIZE_CAPABILITY_OFS;
	// Unmapped places, an unaligned one among them
	localparam logic [11:0] BAD [4] = '{12'h000, 12'h00c, 12'hffc, 12'h006};

	logic        pclk    = 1'b0;  // 50 MHz bus clock
	logic        presetn = 1'b0;  // Bus reset, active low
	logic        psel    = 1'b0;  // Shared request to all variants
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [3:0]  pstrb   = 4'h0;
	logic        pready_a  [3];   // Answers, one per variant
	logic [31:0] prdata_a  [3];
	logic        pslverr_a [3];
	logic [31:0] rd_q [3];        // Answers taken at the access edge
	logic        er_q [3];
	int          error_cnt  = 0;
	int          num_checks = 0;

	always #10 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Three builds side by side so every grade and status code is seen
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_var
		id_cap_regs #(
			.ADDR_W         (12),
			.FORMAT_VERSION (FV),
			.FAMILY_CODE    (FC),
			.PART_NUMBER    (PN),
			.TEMP_GRADE     (TG[3*i +: 3]),
			.QUALIFY_STATUS (QS[2*i +: 2])
		) u_id_cap_regs (
			.pclk    (pclk),
			.presetn (presetn),
			.psel    (psel),
			.penable (penable),
			.pwrite  (pwrite),
			.paddr   (paddr),
			.pwdata  (pwdata),
			.pstrb   (pstrb),
			.pready  (pready_a[i]),
			.prdata  (prdata_a[i]),
			.pslverr (pslverr_a[i])
		);
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] exp_id(input int i);
		return {FV, FC, PN, 8'h00, TG[3*i +: 3], 2'h1, 1'b1, QS[2*i +: 2]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Called just after a rising edge; keeps psel up unless last is set,
	// so a following call starts its setup phase without an idle cycle
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, input logic last);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= {4{wr}};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_a[0] !== 1'b1 && n < 16);
		chk1("pready", 1'b1, pready_a[0]);
		for (int i = 0; i < 3; i++) begin
			rd_q[i] = prdata_a[i];
			er_q[i] = pslverr_a[i];
		end
		if (last) begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Reads both registers back to back; identity checked in every variant, capability and error flags in variant 0 only
	task automatic read_both(input string nm);
		xfer(1'b0, ID_A, 32'h0, 1'b0);
		for (int i = 0; i < 3; i++) chk(nm, exp_id(i), rd_q[i]);
		chk1("id err", 1'b0, er_q[0]);
		xfer(1'b0, MC_A, 32'h0, 1'b1);
		chk(nm, 32'h0007_0007, rd_q[0]);
		chk1("cap err", 1'b0, er_q[0]);
		@(posedge pclk);
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		chk("reset data", 32'h0, prdata_a[0]);
		chk1("reset err", 1'b0, pslverr_a[0]);
		presetn <= 1'b1;
		@(posedge pclk);
		read_both("first read");
		// Writes of all ones must leave both words untouched
		xfer(1'b1, ID_A, 32'hffff_ffff, 1'b0);
		chk1("wr id err", 1'b0, er_q[0]);
		// Read straight after the write, with no idle cycle between
		xfer(1'b0, ID_A, 32'h0, 1'b0);
		chk("wr id rd", exp_id(0), rd_q[0]);
		xfer(1'b1, MC_A, 32'hffff_ffff, 1'b1);
		chk1("wr cap err", 1'b0, er_q[0]);
		chk("wr data", 32'h0, rd_q[0]);
		@(posedge pclk);
		read_both("after write");
		// Unmapped reads and writes answer an error and no data
		foreach (BAD[k]) begin
			xfer(1'b0, BAD[k], 32'h0, 1'b0);
			chk1("bad rd err", 1'b1, er_q[0]);
			chk("bad rd data", 32'h0, rd_q[0]);
			xfer(1'b1, BAD[k], 32'ha5a5_5a5a, 1'b0);
			chk1("bad wr err", 1'b1, er_q[0]);
		end
		// The error must not linger into the next mapped access
		read_both("after error");
		chk1("err idle", 1'b0, pslverr_a[0]);
		// Reset in mid-run, then the fixed values return unchanged
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("mid reset data", 32'h0, prdata_a[0]);
		presetn <= 1'b1;
		@(posedge pclk);
		read_both("after reset");
		tally_and_finish();
	end

endmodule // device_identity_capability_regs_bench
